// File: sim/dac_dither_sequencer_bench.sv
// Self-checking bench for the dither sequencer
`timescale 1ns/1ns
`default_nettype none

module dac_dither_sequencer_bench;
   typedef struct packed {logic [7:0] b; logic [3:0] f; logic [15:0] m;} dds_row_s;
   logic ref_clk, reset = 1, target_load = 0, closed_loop = 0, raw_check = 0;
   logic auto_en = 1, burst_go = 0, adc_valid, adc_ready, adc_start, dac_load;
   logic frame_start, meas_valid, raw_valid;
   logic [7:0] base_in = 8'h00, dac_code, eff_base;
   logic [3:0] factor_in = 4'h0, eff_factor;
   logic [9:0] burst_val = 10'h000, adc_data;
   logic [11:0] meas_level, raw_level;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   dds_row_s rows [16] = '{'{8'h80, 4'h0, 16'h0000}, '{8'h80, 4'h1, 16'h0001},
      '{8'h4A, 4'h2, 16'h0101}, '{8'h80, 4'h3, 16'h0421}, '{8'h00, 4'h4, 16'h1111},
      '{8'hFF, 4'h5, 16'h1249}, '{8'h80, 4'h6, 16'h2525}, '{8'h80, 4'h7, 16'h2A55},
      '{8'h4A, 4'h8, 16'h5555}, '{8'h80, 4'h9, 16'hD5AA}, '{8'h7F, 4'hA, 16'hDADA},
      '{8'h80, 4'hB, 16'hEDB6}, '{8'h80, 4'hC, 16'hEEEE}, '{8'hFE, 4'hD, 16'hFBDE},
      '{8'h80, 4'hE, 16'hFEFE}, '{8'hFF, 4'hF, 16'hFFFE}};

   dds_sequencer dds_sequencer_inst (.ref_clk, .reset, .base_in, .factor_in, .target_load,
      .closed_loop, .raw_check, .adc_data, .adc_valid, .adc_ready, .adc_start, .dac_code,
      .dac_load, .frame_start, .eff_base, .eff_factor, .meas_level, .meas_valid,
      .raw_level, .raw_valid);
   dds_adc_model dds_adc_model_inst (.ref_clk, .reset, .dac_code, .adc_start, .adc_ready,
      .auto_en, .burst_go, .burst_val, .adc_data, .adc_valid);

   initial begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end

   task chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task final_report;
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Guard against a hung handshake
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 130000) begin
         n_fail++;
         final_report;
      end
   end

   task load_tgt(input logic [7:0] b, input logic [3:0] f);
      base_in = b;
      factor_in = f;
      target_load = 1;
      @(posedge ref_clk);
      #1 target_load = 0;
      chk({eff_base, eff_factor}, {b, f});
   endtask

   task wait_load;
      for (int j = 0; j < 500; j++) begin
         @(posedge ref_clk);
         #1;
         if (dac_load === 1'b1) break;
      end
   endtask

   // Offer one value until n samples are taken; the offer drops right after the last
   task burst(input logic [9:0] v, input int n);
      burst_val = v;
      burst_go = 1;
      // Ready is read while settled; the next edge takes the sample when it is high
      for (int j = 0; j < n; ) begin
         if (adc_ready === 1'b1) j++;
         @(posedge ref_clk);
         #1;
      end
      burst_go = 0;
      repeat (40) @(posedge ref_clk);
      #1;
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      #1 reset = 0;
      @(posedge ref_clk);
      #1 chk({dac_code, eff_factor}, 12'h000);
      chk(12'(adc_ready), 12'h001);
      load_tgt(rows[0].b, rows[0].f);
      // Next target lands mid-frame and must wait for the frame boundary
      for (int i = 0; i < 16; i++) begin
         for (int s = 0; s < 16; s++) begin
            wait_load();
            chk(12'(frame_start), 12'(s == 0));
            chk(12'(dac_code), 12'(rows[i].b == 8'hFF ? 8'hFF
               : rows[i].b + {7'h00, rows[i].m[s]}));
            if (s == 1 && i < 15) load_tgt(rows[i+1].b, rows[i+1].f);
         end
      end
      auto_en = 0;
      repeat (40) @(posedge ref_clk);
      #1 load_tgt(8'h10, 4'hF);
      // Sums arrive as a pulse; wait has already passed so keep the level
      // Group count runs on from earlier samples; 32 give one whole group of this value
      burst(10'h0C3, 32);
      chk(meas_level, 12'h30C);
      raw_check = 1;
      burst(10'h155, 32);
      chk(raw_level, 12'h554);
      repeat (17) wait_load();
      chk(12'(dac_code), 12'h010);
      raw_check = 0;
      closed_loop = 1;
      load_tgt(8'h10, 4'hF);
      burst(10'h03F, 256);
      chk({eff_base, eff_factor}, 12'h110);
      burst(10'h050, 256);
      chk({eff_base, eff_factor}, 12'h10F);
      closed_loop = 0;
      final_report;
   end
endmodule // dac_dither_sequencer_bench

`default_nettype wire

// File: sim/dds_adc_model.sv
// Converter model: ideal DAC level sampled on request, or a bench-driven burst
`timescale 1ns/1ns
`default_nettype none

module dds_adc_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] dac_code,
   input wire logic adc_start,
   input wire logic adc_ready,
   input wire logic auto_en,
   input wire logic burst_go,
   input wire logic [9:0] burst_val,
   output logic [9:0] adc_data,
   output logic adc_valid
);
   logic [9:0] smp_r;
   logic [3:0] dly_r;
   logic pend_r;
   logic vld_r;

   // Conversion lags the request; the offer holds until taken, then data inverts
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pend_r <= 1'b0;
         vld_r <= 1'b0;
         dly_r <= 4'h0;
         smp_r <= 10'h000;
      end else begin
         if (adc_start && auto_en) begin
            pend_r <= 1'b1;
            dly_r <= 4'h7;
         end else if (pend_r && dly_r != 4'h0) begin
            dly_r <= dly_r - 4'h1;
         end else if (pend_r) begin
            pend_r <= 1'b0;
            vld_r <= 1'b1;
            smp_r <= {dac_code, 2'b00};
         end
         if (vld_r && adc_ready) begin
            vld_r <= 1'b0;
            smp_r <= ~smp_r;
         end
      end
   end

   // Burst mode lets the bench fill windows far faster than the request rate
   assign adc_valid = vld_r | burst_go;
   assign adc_data = burst_go ? burst_val : smp_r;
endmodule // dds_adc_model

`default_nettype wire

// File: sim/dds_seq_chk_sva.sv
// Port-level timing checks for the dither sequencer
`timescale 1ns/1ns
`default_nettype none

module dds_seq_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] base_in,
   input wire logic [3:0] factor_in,
   input wire logic target_load,
   input wire logic closed_loop,
   input wire logic adc_start,
   input wire logic [7:0] dac_code,
   input wire logic dac_load,
   input wire logic frame_start,
   input wire logic [7:0] eff_base,
   input wire logic [3:0] eff_factor,
   input wire logic meas_valid,
   input wire logic raw_valid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [10:0] cl_r;
   logic [10:0] cs_r;
   logic [3:0] st_r;

   // Cycles since last update and request; step count within the frame
   always_ff @(posedge ref_clk) begin
      cl_r <= (reset || dac_load) ? 11'h000 : cl_r + 11'h001;
      cs_r <= (reset || adc_start) ? 11'h000 : cs_r + 11'h001;
      st_r <= reset ? 4'h0 : st_r + {3'h0, dac_load};
   end

   chk_load_gap: assert property (dac_load |-> cl_r inside {11'h18F, 11'h190})
      else $error("update spacing wrong");
   chk_load_due: assert property (cl_r <= 11'h190)
      else $error("update overdue");
   chk_code_stands: assert property (!dac_load |-> $stable(dac_code))
      else $error("code moved without update");
   chk_frame_mark: assert property (dac_load |-> frame_start == (st_r == 4'h0))
      else $error("frame mark on wrong step");
   chk_frame_alone: assert property (frame_start |-> dac_load)
      else $error("frame mark without update");
   chk_target_take: assert property (target_load |=>
      {eff_base, eff_factor} == $past({base_in, factor_in}))
      else $error("target not taken");
   chk_open_hold: assert property (!target_load && !closed_loop |=>
      $stable({eff_base, eff_factor}))
      else $error("open loop value moved");
   chk_req_pulse: assert property (adc_start |=> !adc_start [*8])
      else $error("request pulse too close");
   chk_req_due: assert property (cs_r <= 11'h4C4)
      else $error("request overdue");
   chk_sum_pulse: assert property (meas_valid |-> !raw_valid ##1 !meas_valid)
      else $error("sum pulse wrong");

   cov_frame: cover property (frame_start);
   cov_meas: cover property (meas_valid);
   cov_raw: cover property (raw_valid);
endmodule // dds_seq_chk

bind dds_sequencer dds_seq_chk dds_seq_chk_inst (.ref_clk, .reset, .base_in, .factor_in,
   .target_load, .closed_loop, .adc_start, .dac_code, .dac_load, .frame_start, .eff_base,
   .eff_factor, .meas_valid, .raw_valid);

`default_nettype wire

// File: verilog/dds_fifo.sv
// Sample buffer with registered read data and valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module dds_fifo
   import dds_pkg::*;
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic in_ready;
      logic [WIDTH-1:0] out_data;
      logic out_valid;
   } dds_fifo_s;

   dds_fifo_s s_r;
   dds_fifo_s s_nxt;

   // Output register refills whenever it is empty or being taken
   always_comb begin
      logic push;
      logic pop_out;
      logic load_out;
      push = in_valid & s_r.in_ready;
      pop_out = s_r.out_valid & out_ready;
      load_out = (~s_r.out_valid | pop_out) & (s_r.count != '0);
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr = s_r.wr + 1'b1;
      end
      if (load_out) begin
         s_nxt.out_data = s_r.mem[s_r.rd];
         s_nxt.rd = s_r.rd + 1'b1;
         s_nxt.out_valid = 1'b1;
      end else if (pop_out) begin
         s_nxt.out_valid = 1'b0;
      end
      s_nxt.count = s_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load_out};
      // Ready is registered so a full buffer refuses from the next edge on
      s_nxt.in_ready = (s_nxt.count < FULL_CNT);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready = s_r.in_ready;
   assign out_data = s_r.out_data;
   assign out_valid = s_r.out_valid;

endmodule // dds_fifo

`default_nettype wire

// File: verilog/dds_params.svh
// Constants for the DAC dither sequencer: widths, tick rates and cycle counts
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH

// Clock
`define DDS_CLK_HZ 20000000
// Output update period, ns, and the cycle count derived from it
`define DDS_UPD_TIME_NS 20000
`define DDS_UPD_CYC ((`DDS_UPD_TIME_NS * (`DDS_CLK_HZ / 1000000)) / 1000)
// Sampling tick rate, Hz, and its period in cycles (rounded down)
`define DDS_SAMP_HZ 16384
`define DDS_SAMP_CYC (`DDS_CLK_HZ / `DDS_SAMP_HZ)
// Counter widths
`define DDS_UPD_W 9
`define DDS_SAMP_W 11
// Data widths
`define DDS_CODE_W 8
`define DDS_FACT_W 4
`define DDS_ADC_W 10
`define DDS_LVL_W 12
`define DDS_SUM16_W 14
`define DDS_SUM256_W 18
// Pattern length and correction interval in samples
`define DDS_STEPS 16
`define DDS_GRP_LAST 4'hF
`define DDS_CORR_LAST 8'hFF
// Code range limits
`define DDS_CODE_MAX 8'hFF
`define DDS_LVL_MAX 12'hFFF
`define DDS_LVL_MIN 12'h000
// Sample buffer shape
`define DDS_FIFO_DEPTH 16

`endif

// File: verilog/dds_pkg.sv
// Types shared by the DAC dither sequencer
`include "dds_params.svh"

package dds_pkg;

   // Corrector phase: collect samples, or apply one correction step
   typedef enum logic [0:0] {
      DDS_ST_RUN,
      DDS_ST_ADJUST
   } dds_mode_e;

   // Complete state of the sequencer
   typedef struct packed {
      dds_mode_e mode;
      logic [`DDS_UPD_W-1:0] upd_cnt;
      logic [`DDS_SAMP_W-1:0] samp_cnt;
      logic [3:0] step;
      logic [`DDS_STEPS-1:0] pat;
      logic [`DDS_CODE_W-1:0] fr_base;
      logic [`DDS_LVL_W-1:0] target;
      logic [`DDS_LVL_W-1:0] work;
      logic [`DDS_CODE_W-1:0] dac_code;
      logic dac_load;
      logic frame_start;
      logic adc_start;
      logic [`DDS_SUM16_W-1:0] sum16;
      logic [3:0] grp_cnt;
      logic [`DDS_SUM256_W-1:0] sum256;
      logic [7:0] corr_cnt;
      logic [`DDS_LVL_W-1:0] meas_level;
      logic meas_valid;
      logic [`DDS_LVL_W-1:0] raw_level;
      logic raw_valid;
   } dds_state_s;

endpackage

// File: verilog/dds_sequencer.sv
// DAC dither sequencer: 16-step pattern generator with closed-loop correction
`timescale 1ns/1ns
`default_nettype none
`include "dds_params.svh"

module dds_sequencer
   import dds_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [`DDS_CODE_W-1:0] base_in,
   input wire logic [`DDS_FACT_W-1:0] factor_in,
   input wire logic target_load,
   input wire logic closed_loop,
   input wire logic raw_check,
   input wire logic [`DDS_ADC_W-1:0] adc_data,
   input wire logic adc_valid,
   output logic adc_ready,
   output logic adc_start,
   output logic [`DDS_CODE_W-1:0] dac_code,
   output logic dac_load,
   output logic frame_start,
   output logic [`DDS_CODE_W-1:0] eff_base,
   output logic [`DDS_FACT_W-1:0] eff_factor,
   output logic [`DDS_LVL_W-1:0] meas_level,
   output logic meas_valid,
   output logic [`DDS_LVL_W-1:0] raw_level,
   output logic raw_valid
);

   localparam logic [`DDS_UPD_W-1:0] UPD_LAST = `DDS_UPD_W'(`DDS_UPD_CYC - 1);
   localparam logic [`DDS_SAMP_W-1:0] SAMP_LAST = `DDS_SAMP_W'(`DDS_SAMP_CYC - 1);

   // Adder column for a factor; bit k serves step k (first state in bit 0)
   function automatic logic [`DDS_STEPS-1:0] dds_mask(input logic [`DDS_FACT_W-1:0] f);
      logic [`DDS_STEPS-1:0] m;
      case (f)
         4'h0: m = 16'h0000;
         4'h1: m = 16'h0001;
         4'h2: m = 16'h0101;
         4'h3: m = 16'h0421;
         4'h4: m = 16'h1111;
         4'h5: m = 16'h1249;
         4'h6: m = 16'h2525;
         4'h7: m = 16'h2A55;
         4'h8: m = 16'h5555;
         4'h9: m = 16'hD5AA;
         4'hA: m = 16'hDADA;
         4'hB: m = 16'hEDB6;
         4'hC: m = 16'hEEEE;
         4'hD: m = 16'hFBDE;
         4'hE: m = 16'hFEFE;
         4'hF: m = 16'hFFFE;
         default: m = 16'h0000;
      endcase
      return m;
   endfunction

   // Base plus one pattern bit, clipped so the top code cannot roll to zero
   function automatic logic [`DDS_CODE_W-1:0] dds_code(input logic [`DDS_CODE_W-1:0] b,
                                                      input logic bit_sel);
      logic [`DDS_CODE_W-1:0] c;
      c = b;
      if (bit_sel && b != `DDS_CODE_MAX) begin
         c = b + 8'h01;
      end
      return c;
   endfunction

   dds_state_s s_r;
   dds_state_s s_nxt;

   logic fifo_valid;
   logic [`DDS_ADC_W-1:0] fifo_data;
   logic fifo_pop;

   // Samples queue here so a correction cycle never drops a conversion
   dds_fifo #(
      .WIDTH(`DDS_ADC_W),
      .DEPTH(`DDS_FIFO_DEPTH)
   ) dds_fifo_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_data(adc_data),
      .in_valid(adc_valid),
      .in_ready(adc_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // The drain stalls during the one-cycle correction step
   assign fifo_pop = (s_r.mode == DDS_ST_RUN);

   // Next-state logic
   always_comb begin
      logic [`DDS_SUM16_W-1:0] s16;
      logic [`DDS_LVL_W-1:0] meas256;
      logic [`DDS_CODE_W-1:0] fb;
      logic [`DDS_STEPS-1:0] fp;
      s16 = s_r.sum16 + {4'h0, fifo_data};
      meas256 = s_r.sum256[`DDS_SUM256_W-1:6];
      fb = s_r.work[`DDS_LVL_W-1:`DDS_FACT_W];
      fp = raw_check ? '0 : dds_mask(s_r.work[`DDS_FACT_W-1:0]);
      s_nxt = s_r;
      s_nxt.dac_load = 1'b0;
      s_nxt.frame_start = 1'b0;
      s_nxt.adc_start = 1'b0;
      s_nxt.meas_valid = 1'b0;
      s_nxt.raw_valid = 1'b0;

      // Update tick: one new code per period, frame rearms after step 15
      if (s_r.upd_cnt == UPD_LAST) begin
         s_nxt.upd_cnt = '0;
         s_nxt.dac_load = 1'b1;
         s_nxt.step = s_r.step + 4'h1;
         if (s_r.step == 4'h0) begin
            // Frame values are latched here so a new target never splits a frame
            s_nxt.fr_base = fb;
            s_nxt.pat = fp;
            s_nxt.frame_start = 1'b1;
            s_nxt.dac_code = dds_code(fb, fp[0]);
         end else begin
            s_nxt.dac_code = dds_code(s_r.fr_base, s_r.pat[s_r.step]);
         end
      end else begin
         s_nxt.upd_cnt = s_r.upd_cnt + 1'b1;
      end

      // Conversion request tick
      if (s_r.samp_cnt == SAMP_LAST) begin
         s_nxt.samp_cnt = '0;
         s_nxt.adc_start = 1'b1;
      end else begin
         s_nxt.samp_cnt = s_r.samp_cnt + 1'b1;
      end

      case (s_r.mode)
         DDS_ST_RUN: begin
            if (fifo_valid) begin
               s_nxt.grp_cnt = s_r.grp_cnt + 4'h1;
               s_nxt.sum256 = s_r.sum256 + {8'h00, fifo_data};
               s_nxt.corr_cnt = s_r.corr_cnt + 8'h01;
               if (s_r.grp_cnt == `DDS_GRP_LAST) begin
                  s_nxt.sum16 = '0;
                  // Sum of 16 ten-bit samples, top 12 bits as the level
                  if (raw_check) begin
                     s_nxt.raw_level = s16[`DDS_SUM16_W-1:2];
                     s_nxt.raw_valid = 1'b1;
                  end else begin
                     s_nxt.meas_level = s16[`DDS_SUM16_W-1:2];
                     s_nxt.meas_valid = 1'b1;
                  end
               end else begin
                  s_nxt.sum16 = s16;
               end
               if (s_r.corr_cnt == `DDS_CORR_LAST && closed_loop && !raw_check) begin
                  s_nxt.mode = DDS_ST_ADJUST;
               end else if (s_r.corr_cnt == `DDS_CORR_LAST) begin
                  s_nxt.sum256 = '0; // Open loop or raw check: window discarded
               end
            end
         end
         DDS_ST_ADJUST: begin
            // Bang-bang step on the whole 12-bit value carries into the base
            if (meas256 < s_r.target && s_r.work != `DDS_LVL_MAX) begin
               s_nxt.work = s_r.work + 12'h001;
            end else if (meas256 > s_r.target && s_r.work != `DDS_LVL_MIN) begin
               s_nxt.work = s_r.work - 12'h001;
            end
            s_nxt.sum256 = '0;
            s_nxt.mode = DDS_ST_RUN;
         end
         default: begin
            s_nxt.mode = DDS_ST_RUN;
         end
      endcase

      // A new target overrides any correction taken in the same cycle
      if (target_load) begin
         s_nxt.target = {base_in, factor_in};
         s_nxt.work = {base_in, factor_in};
         s_nxt.sum256 = '0;
         s_nxt.corr_cnt = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dac_code = s_r.dac_code;
   assign dac_load = s_r.dac_load;
   assign frame_start = s_r.frame_start;
   assign adc_start = s_r.adc_start;
   assign eff_base = s_r.work[`DDS_LVL_W-1:`DDS_FACT_W];
   assign eff_factor = s_r.work[`DDS_FACT_W-1:0];
   assign meas_level = s_r.meas_level;
   assign meas_valid = s_r.meas_valid;
   assign raw_level = s_r.raw_level;
   assign raw_valid = s_r.raw_valid;

endmodule // dds_sequencer

`default_nettype wire
